// File: hw/lsr_pkg.sv
// Constants and types shared by the lane swap and reset control block
`default_nettype none
package lsr_pkg;

  // Lane layout: indices 0..2 are data lanes, index 3 is the clock lane
  localparam int LANES = 4;
  localparam int DATA_LANES = 3;
  localparam int CLK_LANE = 3;

  // Register map, 8-bit address and data
  localparam logic [7:0] ADDR_CTRL = 8'h09;
  localparam logic [7:0] ADDR_MODE = 8'h0A;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_ERR0 = 8'h11;
  localparam logic [7:0] ADDR_ERR1 = 8'h12;
  localparam logic [7:0] ADDR_ERR2 = 8'h13;
  localparam logic [7:0] ADDR_EYE_SEL = 8'h14;
  localparam logic [7:0] ADDR_EYE = 8'h15;

  // Field positions
  localparam int CTRL_SWAP_BIT = 7;
  localparam int CTRL_POL_BIT = 6;
  localparam int STAT_OE_BIT = 0;
  localparam int STAT_SWAP_BIT = 1;
  localparam int STAT_POL_BIT = 2;
  localparam int STAT_CDR_ON_BIT = 3;
  localparam int STAT_CDR_ACT_BIT = 4;
  localparam int STAT_FAST_BIT = 5;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] EYE_SEL_RESET = 2'h0;
  localparam logic [7:0] ERR_RESET = 8'h00;

  typedef enum logic [1:0] {
    LSR_MODE_AUTO,
    LSR_MODE_REDRIVER,
    LSR_MODE_RETIMER,
    LSR_MODE_SPARE
  } lsr_mode_t;

  typedef enum logic [1:0] {
    LSR_CDR_OFF,
    LSR_CDR_ACQ,
    LSR_CDR_ON
  } lsr_cdr_t;

  // Timing, clock 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int OE_LOW_MIN_US = 100;
  localparam int OE_LOW_MIN_CYC = (OE_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CDR_ON_MAX_MS = 15;
  localparam int CDR_ON_MAX_CYC = (CDR_ON_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CDR_OFF_MAX_NS = 120;
  localparam int CDR_OFF_MAX_CYC = CDR_OFF_MAX_NS / CLK_PERIOD_NS;
  localparam int CDR_CNT_W = 19;

  // Lane clock rate detector, in core cycles per lane clock period, then checker saturation and fill limits
  localparam logic [7:0] RATE_FAST_MAX_CYC = 8'h0A;
  localparam logic [7:0] RATE_TIMEOUT_CYC = 8'h40;
  localparam logic [7:0] CNT8_MAX = 8'hFF;
  localparam logic [2:0] CHK_FILL = 3'h7;

endpackage

`default_nettype wire

// File: hw/lsr_sync.sv
// Two flip-flop synchroniser for pins entering the core clock domain
`timescale 1ns/1ps
`default_nettype none

module lsr_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q <= '0;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

// File: hw/lsr_ctrl.sv
// Lane routing, polarity, clock recovery timing and lane checkers
//
// Function
// - Output-enable low ignores control inputs and tristates lane inputs and outputs.
// - Output-enable toggle resets device and discards all register settings.
// - Normal operation starts only once output-enable is high.
// - Clock recovery active within 15 ms after retimer mode starts.
// - Clock recovery off within 120 ns after retimer mode ends.
// - Swap routes lane 2 to clock, 1 to 0, 0 to 1, clock to 2.
// - Swap active when strap pin low or control bit 7 set.
// - Swap remaps inputs only; per-lane settings stay with the physical input lane.
// - Lane swap works the same in redriver and retimer mode.
// - Strap pin high exchanges p and n members of every input lane.
// - Control bit 6 enables the same per-lane polarity inversion.
// - Polarity inversion applies only while the retimer stage is in use.
// - Auto mode below threshold rate drops polarity inversion.
// - Per data lane symbol error counters, readable over the register port.
// - Per data lane eye-quality samples readable over the register port.
// - Auto mode redrives below rate threshold and retimes above it.
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module lsr_ctrl
  import lsr_pkg::*;
#(
  parameter int CDR_LOCK_CYC = CDR_ON_MAX_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic oe_pin,
  input wire logic lane_order_strap,
  input wire logic link_clk_pin,
  input wire logic [LANES-1:0] in_lane_p,
  input wire logic [LANES-1:0] in_lane_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [LANES-1:0] out_lane_p,
  output logic [LANES-1:0] out_lane_n,
  output logic out_lane_oe,
  output logic in_lane_term_en,
  output logic clock_recovery_on,
  output logic clock_recovery_active
);

  // Synchronised pins
  localparam int SYNC_W = 3 + 2 * LANES;
  logic [SYNC_W-1:0] sync_q;
  logic oe_s;
  logic strap_s;
  logic lclk_s;
  logic [LANES-1:0] p_s;
  logic [LANES-1:0] n_s;

  lsr_sync #(.W(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .ce(ce),
    .d({oe_pin, lane_order_strap, link_clk_pin, in_lane_p, in_lane_n}),
    .q(sync_q)
  );

  assign {oe_s, strap_s, lclk_s, p_s, n_s} = sync_q;

  // Lane clock edge finder
  logic lclk_prev_q;
  wire lclk_rise = lclk_s & ~lclk_prev_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lclk_prev_q <= 1'b0;
    end else if (ce) begin
      lclk_prev_q <= lclk_s;
    end
  end

  // Register port decode
  // writes ignored while output-enable is low
  wire wr_ok = reg_wr & oe_s;
  wire wr_ctrl = wr_ok & (reg_addr == ADDR_CTRL);
  wire wr_mode = wr_ok & (reg_addr == ADDR_MODE);
  wire wr_eye_sel = wr_ok & (reg_addr == ADDR_EYE_SEL);
  wire [DATA_LANES-1:0] wr_err_clr;
  assign wr_err_clr[0] = wr_ok & (reg_addr == ADDR_ERR0);
  assign wr_err_clr[1] = wr_ok & (reg_addr == ADDR_ERR1);
  assign wr_err_clr[2] = wr_ok & (reg_addr == ADDR_ERR2);

  logic [7:0] ctrl_q;
  lsr_mode_t mode_q;
  logic [1:0] eye_sel_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      mode_q <= LSR_MODE_AUTO;
      eye_sel_q <= EYE_SEL_RESET;
    end else if (ce) begin
      if (!oe_s) begin
        ctrl_q <= CTRL_RESET;
        mode_q <= LSR_MODE_AUTO;
        eye_sel_q <= EYE_SEL_RESET;
      end else begin
        if (wr_ctrl) begin
          ctrl_q <= reg_wdata;
        end
        if (wr_mode) begin
          mode_q <= lsr_mode_t'(reg_wdata[1:0]);
        end
        if (wr_eye_sel) begin
          eye_sel_q <= reg_wdata[1:0];
        end
      end
    end
  end

  // Lane rate detector; a stalled lane clock counts as slow
  logic [7:0] per_cnt_q;
  logic fast_q;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_cnt_q <= 8'h00;
      fast_q <= 1'b0;
    end else if (ce) begin
      if (!oe_s) begin
        per_cnt_q <= 8'h00;
        fast_q <= 1'b0;
      end else if (lclk_rise) begin
        per_cnt_q <= 8'h00;
        fast_q <= (per_cnt_q < RATE_FAST_MAX_CYC);
      end else if (per_cnt_q == RATE_TIMEOUT_CYC) begin
        fast_q <= 1'b0;
      end else begin
        per_cnt_q <= per_cnt_q + 8'h01;
      end
    end
  end

  // auto mode picks retimer above rate threshold
  wire auto_retime = (mode_q == LSR_MODE_AUTO) & fast_q;
  wire retimer_want = oe_s & ((mode_q == LSR_MODE_RETIMER) | auto_retime);

  // Clock recovery sequencing
  lsr_cdr_t cdr_state_q;
  lsr_cdr_t cdr_state_d;
  logic [CDR_CNT_W-1:0] cdr_cnt_q;
  localparam logic [CDR_CNT_W-1:0] CDR_LAST = CDR_CNT_W'(CDR_LOCK_CYC - 1);

  always_comb begin
    cdr_state_d = cdr_state_q;
    case (cdr_state_q)
      LSR_CDR_OFF: begin
        if (retimer_want) begin
          cdr_state_d = LSR_CDR_ACQ;
        end
      end
      LSR_CDR_ACQ: begin
        if (!retimer_want) begin
          cdr_state_d = LSR_CDR_OFF;
        end else if (cdr_cnt_q == CDR_LAST) begin
          cdr_state_d = LSR_CDR_ON;
        end
      end
      LSR_CDR_ON: begin
        if (!retimer_want) begin
          cdr_state_d = LSR_CDR_OFF;
        end
      end
      default: begin
        cdr_state_d = LSR_CDR_OFF;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cdr_state_q <= LSR_CDR_OFF;
      cdr_cnt_q <= '0;
      clock_recovery_on <= 1'b0;
      clock_recovery_active <= 1'b0;
    end else if (ce) begin
      cdr_state_q <= cdr_state_d;
      if (cdr_state_d == LSR_CDR_ACQ && cdr_state_q == LSR_CDR_ACQ) begin
        cdr_cnt_q <= cdr_cnt_q + 1'b1;
      end else begin
        cdr_cnt_q <= '0;
      end
      clock_recovery_on <= (cdr_state_d != LSR_CDR_OFF);
      clock_recovery_active <= (cdr_state_d == LSR_CDR_ON);
    end
  end

  wire swap_act = ~strap_s | ctrl_q[CTRL_SWAP_BIT];
  wire pol_req = strap_s | ctrl_q[CTRL_POL_BIT];
  // only in the locked retimer stage
  wire pol_act = pol_req & clock_recovery_active;

  // Polarity-corrected input lanes
  wire [LANES-1:0] fix_p = pol_act ? n_s : p_s;
  wire [LANES-1:0] fix_n = pol_act ? p_s : n_s;

  // output position takes its mapped input
  wire [LANES-1:0] route_p;
  wire [LANES-1:0] route_n;
  assign route_p[CLK_LANE] = swap_act ? fix_p[2] : fix_p[CLK_LANE];
  assign route_n[CLK_LANE] = swap_act ? fix_n[2] : fix_n[CLK_LANE];
  assign route_p[2] = swap_act ? fix_p[CLK_LANE] : fix_p[2];
  assign route_n[2] = swap_act ? fix_n[CLK_LANE] : fix_n[2];
  assign route_p[1] = swap_act ? fix_p[0] : fix_p[1];
  assign route_n[1] = swap_act ? fix_n[0] : fix_n[1];
  assign route_p[0] = swap_act ? fix_p[1] : fix_p[0];
  assign route_n[0] = swap_act ? fix_n[1] : fix_n[0];

  // Retimed path updates on lane clock edges only
  wire out_update = ~clock_recovery_active | lclk_rise;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_lane_p <= '0;
      out_lane_n <= '0;
      out_lane_oe <= 1'b0;
      in_lane_term_en <= 1'b0;
    end else if (ce) begin
      out_lane_oe <= oe_s;
      in_lane_term_en <= oe_s;
      if (!oe_s) begin
        out_lane_p <= '0;
        out_lane_n <= '0;
      end else if (out_update) begin
        out_lane_p <= route_p;
        out_lane_n <= route_n;
      end
    end
  end

  // Per data lane checkers, indexed by input lane
  logic [7:0] err_cnt [DATA_LANES];
  logic [7:0] eye_val [DATA_LANES];

  genvar gi;
  generate
    for (gi = 0; gi < DATA_LANES; gi++) begin : g_chk
      logic [6:0] hist_q;
      logic [2:0] fill_q;
      logic [7:0] err_q;
      logic [7:0] stable_q;
      logic [7:0] eye_q;
      logic prev_bit_q;
      wire bit_in = fix_p[gi];
      // Self-synchronising PRBS7 check once history is full
      wire sym_err = lclk_rise & (fill_q == CHK_FILL) & (bit_in != (hist_q[6] ^ hist_q[5]));

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          hist_q <= '0;
          fill_q <= '0;
          err_q <= ERR_RESET;
          stable_q <= 8'h00;
          eye_q <= 8'h00;
          prev_bit_q <= 1'b0;
        end else if (ce) begin
          if (!oe_s) begin
            hist_q <= '0;
            fill_q <= '0;
            err_q <= ERR_RESET;
            stable_q <= 8'h00;
            eye_q <= 8'h00;
            prev_bit_q <= 1'b0;
          end else begin
            prev_bit_q <= bit_in;
            if (bit_in != prev_bit_q) begin
              stable_q <= 8'h00;
            end else if (stable_q != CNT8_MAX) begin
              stable_q <= stable_q + 8'h01;
            end
            if (lclk_rise) begin
              hist_q <= {hist_q[5:0], bit_in};
              eye_q <= stable_q;
              if (fill_q != CHK_FILL) begin
                fill_q <= fill_q + 3'h1;
              end
            end
            // count wins over a clearing write
            if (sym_err && err_q != CNT8_MAX) begin
              err_q <= err_q + 8'h01;
            end else if (!sym_err && wr_err_clr[gi]) begin
              err_q <= ERR_RESET;
            end
          end
        end
      end

      assign err_cnt[gi] = err_q;
      assign eye_val[gi] = eye_q;
    end
  endgenerate

  // Read mux
  wire [7:0] status_val = 8'(
    (oe_s << STAT_OE_BIT) | (swap_act << STAT_SWAP_BIT) | (pol_act << STAT_POL_BIT)
    | (clock_recovery_on << STAT_CDR_ON_BIT) | (clock_recovery_active << STAT_CDR_ACT_BIT)
    | (fast_q << STAT_FAST_BIT));
  wire [7:0] eye_rd = (eye_sel_q < 2'(DATA_LANES)) ? eye_val[eye_sel_q] : 8'h00;
  wire [7:0] rd_mux =
    (reg_addr == ADDR_CTRL) ? ctrl_q :
    (reg_addr == ADDR_MODE) ? {6'h00, mode_q} :
    (reg_addr == ADDR_STATUS) ? status_val :
    (reg_addr == ADDR_ERR0) ? err_cnt[0] :
    (reg_addr == ADDR_ERR1) ? err_cnt[1] :
    (reg_addr == ADDR_ERR2) ? err_cnt[2] :
    (reg_addr == ADDR_EYE_SEL) ? {6'h00, eye_sel_q} :
    (reg_addr == ADDR_EYE) ? eye_rd : 8'h00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (ce) begin
      // Data valid only in the cycle after the read strobe
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

`default_nettype wire

// File: testbench/lsr_ctrl_props.sv
// Port assertions for the lane swap and reset control block
`timescale 1ns/1ps
`default_nettype none

module lsr_ctrl_props
  import lsr_pkg::*;
#(
  parameter int CDR_LOCK_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic oe_pin,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [LANES-1:0] out_lane_p,
  input wire logic [LANES-1:0] out_lane_n,
  input wire logic out_lane_oe,
  input wire logic in_lane_term_en,
  input wire logic clock_recovery_on,
  input wire logic clock_recovery_active
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  int lock_cnt_q;
  // Acquisition time counter, cleared once locked or off
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      lock_cnt_q <= 0;
    else if (clock_recovery_on && !clock_recovery_active)
      lock_cnt_q <= lock_cnt_q + 1;
    else
      lock_cnt_q <= 0;
  end
  a_off_idle: assert property (!oe_pin [*4] |-> !out_lane_oe && !in_lane_term_en
    && out_lane_p == 4'h0 && out_lane_n == 4'h0) else $error("outputs live while disabled");
  a_on_start: assert property (oe_pin [*4] |-> out_lane_oe)
    else $error("outputs not enabled");
  a_off_cdr: assert property (!oe_pin [*5] |-> !clock_recovery_on)
    else $error("recovery on while disabled");
  a_lock_bound: assert property (lock_cnt_q <= CDR_LOCK_CYC + 2)
    else $error("recovery lock too slow");
  a_lock_later: assert property ($rose(clock_recovery_on) |-> !clock_recovery_active)
    else $error("locked at power up");
  a_act_on: assert property (clock_recovery_active |-> clock_recovery_on)
    else $error("locked while off");
  a_off_time: assert property (reg_wr && reg_addr == ADDR_MODE && reg_wdata[1:0] == 2'h1
    |-> ##[1:3] !clock_recovery_on) else $error("recovery off too slow");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
endmodule

bind lsr_ctrl lsr_ctrl_props #(.CDR_LOCK_CYC(CDR_LOCK_CYC)) lsr_ctrl_props_i (
  .core_clk(core_clk), .rst(rst), .oe_pin(oe_pin), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .out_lane_p(out_lane_p), .out_lane_n(out_lane_n), .out_lane_oe(out_lane_oe),
  .in_lane_term_en(in_lane_term_en), .clock_recovery_on(clock_recovery_on),
  .clock_recovery_active(clock_recovery_active));

`default_nettype wire

// File: testbench/lsr_src.sv
// Behavioural video source driving the serial lanes
`timescale 1ns/1ps
`default_nettype none

module lsr_src (
  input wire logic run,
  input wire logic [3:0] p_val,
  input wire logic [3:0] n_val,
  output logic link_clk_pin,
  output logic [3:0] in_lane_p,
  output logic [3:0] in_lane_n
);
  logic clk_q = 1'b0;
  logic [3:0] p_q = 4'h0;
  logic [3:0] n_q = 4'hF;
  assign link_clk_pin = clk_q;
  assign in_lane_p = p_q;
  assign in_lane_n = n_q;
  // Own time base, off the core grid; clock stands low when idle
  initial begin
    #7;
    forever begin
      #160;
      clk_q = run ? !clk_q : 1'b0;
      // Launch data at the fall so it is settled at the rise
      if (!clk_q) begin
        p_q = p_val;
        n_q = n_val;
      end
    end
  end
endmodule

`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the lane swap and reset control block
`timescale 1ns/1ps
`default_nettype none

module testbench
  import lsr_pkg::*;
();
  localparam int LOCK = 20;
  localparam int LIMIT = 15000;
  logic core_clk, rst, oe_pin, lane_order_strap, reg_wr, reg_rd, run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] p_val, n_val, in_lane_p, in_lane_n, out_lane_p, out_lane_n;
  logic link_clk_pin, out_lane_oe, in_lane_term_en, clock_recovery_on, clock_recovery_active;
  logic [31:0] seed = 32'h8FC1728D;
  int fails, total_checks, cyc, sw, pol;

  lsr_ctrl #(.CDR_LOCK_CYC(LOCK)) lsr_ctrl_i (.core_clk(core_clk), .rst(rst), .ce(1'b1),
    .oe_pin(oe_pin), .lane_order_strap(lane_order_strap), .link_clk_pin(link_clk_pin),
    .in_lane_p(in_lane_p), .in_lane_n(in_lane_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .out_lane_p(out_lane_p), .out_lane_n(out_lane_n), .out_lane_oe(out_lane_oe),
    .in_lane_term_en(in_lane_term_en), .clock_recovery_on(clock_recovery_on),
    .clock_recovery_active(clock_recovery_active));
  lsr_src lsr_src_i (.run(run), .p_val(p_val), .n_val(n_val), .link_clk_pin(link_clk_pin),
    .in_lane_p(in_lane_p), .in_lane_n(in_lane_n));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails = fails + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    step(1);
    reg_wr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    step(1);
    reg_rd <= 1'b1;
    reg_addr <= a;
    step(1);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", 32'(reg_rdata), 32'(e));
  endtask

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Reference lane map: members exchanged first, then reordered
  function automatic logic [7:0] route(input logic [3:0] p, input logic [3:0] n, input int s,
    input int v);
    logic [3:0] a, b;
    a = v ? n : p;
    b = v ? p : n;
    if (s) begin
      a = {a[2], a[3], a[0], a[1]};
      b = {b[2], b[3], b[0], b[1]};
    end
    return {a, b};
  endfunction

  task automatic lanes(input int rt);
    logic [31:0] v;
    for (int i = 0; i < 8; i++) begin
      v = xs();
      step(1);
      p_val <= v[3:0];
      n_val <= v[7:4];
      lane_order_strap <= v[8];
      wr(ADDR_CTRL, {v[9], v[10], 6'h00});
      step(rt ? 28 : 10);
      #1;
      sw = !v[8] || v[9];
      pol = rt && (v[8] || v[10]);
      chk("lanes", 32'({out_lane_p, out_lane_n}), 32'(route(v[3:0], v[7:4], sw, pol)));
    end
  endtask

  initial begin
    rst = 1'b1;
    oe_pin = 1'b0;
    lane_order_strap = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    run = 1'b0;
    p_val = 4'h0;
    n_val = 4'h0;
    step(20);
    rst <= 1'b0;
    wr(ADDR_CTRL, 8'h80);
    step(4);
    #1;
    chk("idle", 32'({out_lane_oe, in_lane_term_en, out_lane_p, out_lane_n}), 32'h0);
    step(OE_LOW_MIN_CYC);
    oe_pin <= 1'b1;
    step(5);
    #1;
    chk("enabled", 32'({out_lane_oe, in_lane_term_en}), 32'h3);
    rdc(ADDR_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h01);
    lanes(0);
    wr(ADDR_MODE, 8'h02);
    run <= 1'b1;
    step(3);
    #1;
    chk("cdr on", 32'(clock_recovery_on), 32'h1);
    step(LOCK + 2);
    #1;
    chk("cdr active", 32'(clock_recovery_active), 32'h1);
    lanes(1);
    step(1);
    p_val <= 4'hF;
    n_val <= 4'hF;
    wr(ADDR_CTRL, 8'h00);
    step(2600);
    for (int i = 0; i < 3; i++) rdc(ADDR_ERR0 + 8'(i), 8'hFF);
    step(1);
    run <= 1'b0;
    step(16);
    wr(ADDR_ERR1, 8'h00);
    rdc(ADDR_ERR1, 8'h00);
    rdc(ADDR_ERR2, 8'hFF);
    // Lane 0 bit held for thousands of cycles, opening saturates
    rdc(ADDR_EYE, 8'hFF);
    wr(ADDR_EYE_SEL, 8'h03);
    rdc(ADDR_EYE, 8'h00);
    rdc(8'hFF, 8'h00);
    wr(ADDR_MODE, 8'h01);
    step(3);
    #1;
    chk("cdr off", 32'(clock_recovery_on), 32'h0);
    wr(ADDR_MODE, 8'h00);
    run <= 1'b1;
    step(LOCK + 60);
    #1;
    chk("auto fast", 32'(clock_recovery_active), 32'h1);
    step(1);
    run <= 1'b0;
    // Strap high asks for inversion, which must not survive the slow rate
    lane_order_strap <= 1'b1;
    p_val <= 4'h5;
    n_val <= 4'hA;
    step(90);
    #1;
    chk("auto slow", 32'(clock_recovery_active), 32'h0);
    chk("no invert", 32'({out_lane_p, out_lane_n}), 32'(route(4'h5, 4'hA, 0, 0)));
    rdc(ADDR_STATUS, 8'h01);
    wr(ADDR_CTRL, 8'hC0);
    wr(ADDR_MODE, 8'h02);
    rdc(ADDR_CTRL, 8'hC0);
    step(1);
    oe_pin <= 1'b0;
    step(OE_LOW_MIN_CYC);
    oe_pin <= 1'b1;
    step(5);
    rdc(ADDR_CTRL, 8'h00);
    rdc(ADDR_MODE, 8'h00);
    rdc(ADDR_ERR2, 8'h00);
    wr(ADDR_CTRL, 8'h80);
    rdc(ADDR_CTRL, 8'h80);
    summarize();
  end
endmodule

`default_nettype wire
